// >>> shared/vmxs_params.svh
`ifndef VMXS_PARAMS_SVH
`define VMXS_PARAMS_SVH

// register byte offsets on the apb port
`define VMXS_OFF_CTRL      8'h00
`define VMXS_OFF_REASON    8'h04
`define VMXS_OFF_QUAL      8'h08
`define VMXS_OFF_STATUS    8'h0c
`define VMXS_OFF_INJ       8'h10
`define VMXS_OFF_XINFO     8'h14

// control field positions and reset value
`define VMXS_CTRL_EN       0
`define VMXS_CTRL_PDPTR    1
`define VMXS_CTRL_STORE    2
`define VMXS_CTRL_RST      32'h0000_0007

// status field positions
`define VMXS_ST_BUSY       0
`define VMXS_ST_FAIL       1
`define VMXS_ST_SHUT       2
`define VMXS_ST_NMIBLK     3
`define VMXS_ST_MCX        4
`define VMXS_ST_SECSHUT    5

// exit-reason and injection layout
`define VMXS_RSN_FAIL_BIT  31
`define VMXS_INJ_VALID_BIT 31

// basic causes of late entry failure
`define VMXS_BASIC_GUEST   16'h0021
`define VMXS_BASIC_MSR     16'h0022
`define VMXS_BASIC_MC      16'h0029

// qualification values for invalid guest state
`define VMXS_QUAL_NONE     32'h0000_0000
`define VMXS_QUAL_PDPTR    32'h0000_0002
`define VMXS_QUAL_LINK     32'h0000_0004
`define VMXS_QUAL_STI_NMI  32'h0000_0003

// secure-mode shutdown error code
`define VMXS_SHUT_CODE     16'h000c

// apb wait states inserted before pready
`define VMXS_APB_WAIT      1

`endif

// >>> shared/vmxs_pkg.sv
package vmxs_pkg;

  // sequencer states, gray along exit path
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_RECORD = 4'h1,
    ST_SAVE   = 4'h3,
    ST_STORE  = 4'h2,
    ST_LOAD   = 4'h6,
    ST_PDPTR  = 4'h7,
    ST_DONE   = 4'h5,
    ST_MC     = 4'hc
  } vmxs_state_e;

  // what started the current sequence
  typedef enum logic [1:0] {
    CAUSE_EXIT  = 2'h0,
    CAUSE_GUEST = 2'h1,
    CAUSE_MSR   = 2'h2,
    CAUSE_MC    = 2'h3
  } vmxs_cause_e;

  // detected guest-state problem kind
  typedef enum logic [1:0] {
    GQ_NONE    = 2'h0,
    GQ_PDPTR   = 2'h1,
    GQ_LINK    = 2'h2,
    GQ_STI_NMI = 2'h3
  } vmxs_gqual_e;

endpackage

// >>> shared/vmxs_bus_if.sv
`timescale 1ns/1ns
// register access strobes between apb front end and sequencer
interface vmxs_bus_if;
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        hit;

  modport apb  (output wr_en, rd_en, addr, wdata, input rdata, hit);
  modport core (input wr_en, rd_en, addr, wdata, output rdata, hit);
endinterface

// >>> core/vmxs_apb.sv
`timescale 1ns/1ns
`include "vmxs_params.svh"
module vmxs_apb (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  vmxs_bus_if.apb          bus
);
  logic        pready_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;
  logic        access;

  // first access cycle captures read data, second one completes
  assign access     = psel & penable;
  assign bus.addr   = paddr;
  assign bus.wdata  = pwdata;
  assign bus.rd_en  = access & ~pready_r & ~pwrite;
  assign bus.wr_en  = access & pready_r & pwrite & bus.hit;
  assign pready     = pready_r;
  assign prdata     = prdata_r;
  assign pslverr    = pslverr_r;

  // one wait state, then answer with data or error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= access & ~pready_r;
      if (access & ~pready_r) begin
        prdata_r  <= (bus.rd_en & bus.hit) ? bus.rdata : 32'h0000_0000;
        pslverr_r <= ~bus.hit;
      end else begin
        pslverr_r <= 1'b0;
      end
    end
  end
endmodule

// >>> core/vmxs_step.sv
`timescale 1ns/1ns
module vmxs_step (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic start,
  input  wire logic ack,
  output logic      req,
  output logic      done
);
  logic req_r;
  logic done_r;

  assign req  = req_r;
  assign done = done_r;

  // request held until the engine acknowledges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_r  <= 1'b0;
      done_r <= 1'b0;
    end else if (start) begin
      req_r  <= 1'b1;
      done_r <= 1'b0;
    end else if (req_r & ack) begin
      req_r  <= 1'b0;
      done_r <= 1'b1;
    end
  end
endmodule

// >>> core/vmxs_seq.sv
`timescale 1ns/1ns
`include "vmxs_params.svh"
module vmxs_seq #(
  parameter logic [31:0] STI_NMI_QUAL = `VMXS_QUAL_STI_NMI,
  parameter int          IDX_W        = 32
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic                  pready,
  output logic [31:0]           prdata,
  output logic                  pslverr,
  input  wire logic             exit_req,
  input  wire logic [15:0]      exit_basic,
  input  wire logic [31:0]      exit_qual_in,
  input  wire logic [31:0]      exit_info_in,
  input  wire logic             dual_monitor_exit,
  input  wire logic             fail_guest_req,
  input  wire logic [1:0]       fail_guest_kind,
  input  wire logic             fail_msr_req,
  input  wire logic [IDX_W-1:0] fail_msr_index,
  input  wire logic             mc_during_entry,
  input  wire logic             guest_loaded,
  input  wire logic             nmi_blocked_before,
  input  wire logic             machine_check_enable,
  input  wire logic             phys_addr_ext_enable,
  input  wire logic             paging_enable,
  input  wire logic             long_mode_active,
  input  wire logic             safer_mode_operation,
  input  wire logic             guest_save_ack,
  input  wire logic             msr_store_ack,
  input  wire logic             host_load_ack,
  input  wire logic             exit_msr_load_ack,
  input  wire logic             pdptr_load_ack,
  output logic                  guest_save_req,
  output logic                  msr_store_req,
  output logic                  host_load_req,
  output logic                  exit_msr_load_req,
  output logic                  pdptr_load_req,
  output logic                  monitor_clear,
  output logic                  mc_exception,
  output logic                  secure_shutdown,
  output logic [15:0]           shutdown_code,
  output logic                  shutdown_state,
  output logic                  nmi_block,
  output logic                  branch_trace_inhibit,
  output logic                  seq_done
);
  if (IDX_W < 1 || IDX_W > 32) begin : g_chk_idx
    $error("IDX_W must be 1 to 32");
  end
  if (STI_NMI_QUAL == `VMXS_QUAL_NONE || STI_NMI_QUAL == 32'h0000_0001) begin : g_chk_q
    $error("STI_NMI_QUAL must be a distinct non-zero code");
  end

  vmxs_bus_if bus ();

  vmxs_pkg::vmxs_state_e state_r, state_nxt;
  vmxs_pkg::vmxs_cause_e cause_r;
  vmxs_pkg::vmxs_gqual_e gkind_r;
  logic [IDX_W-1:0] idx_r;
  logic [31:0]      ctrl_r, reason_r, qual_r, inj_r, xinfo_r;
  logic [31:0]      xqual_r, xinfo_in_r;
  logic [15:0]      xbasic_r;
  logic             dual_r, nmi_before_r, last_fail_r;
  logic             mcx_r, secshut_r, shut_r, nmi_blk_r, inhibit_r, done_r, monclr_r;
  logic [15:0]      shut_code_r;
  logic             save_done, store_done, host_done, xmsr_done, pdptr_done;
  logic             go_save, go_store, go_load, go_pdptr, is_fail, take;
  logic             loads_done, pdptr_need;
  logic [31:0]      rdata;

  // decodes which word offsets are implemented
  function automatic logic addr_hit(input logic [7:0] a);
    return (a == `VMXS_OFF_CTRL) || (a == `VMXS_OFF_REASON) || (a == `VMXS_OFF_QUAL) ||
           (a == `VMXS_OFF_STATUS) || (a == `VMXS_OFF_INJ) || (a == `VMXS_OFF_XINFO);
  endfunction

  // builds the qualification for a guest-state failure
  function automatic logic [31:0] guest_qual(input vmxs_pkg::vmxs_gqual_e k);
    unique case (k)
      vmxs_pkg::GQ_NONE:    return `VMXS_QUAL_NONE;
      vmxs_pkg::GQ_PDPTR:   return `VMXS_QUAL_PDPTR;
      vmxs_pkg::GQ_LINK:    return `VMXS_QUAL_LINK;
      vmxs_pkg::GQ_STI_NMI: return STI_NMI_QUAL;
    endcase
  endfunction

  vmxs_apb u_apb (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pready  (pready),
    .prdata  (prdata),
    .pslverr (pslverr),
    .bus     (bus.apb)
  );

  // handshakes with the state-transfer engines
  vmxs_step u_save (.pclk(pclk), .presetn(presetn), .start(go_save), .ack(guest_save_ack),
                    .req(guest_save_req), .done(save_done));
  vmxs_step u_store (.pclk(pclk), .presetn(presetn), .start(go_store), .ack(msr_store_ack),
                     .req(msr_store_req), .done(store_done));
  vmxs_step u_host (.pclk(pclk), .presetn(presetn), .start(go_load & ~dual_r),
                    .ack(host_load_ack), .req(host_load_req), .done(host_done));
  vmxs_step u_xmsr (.pclk(pclk), .presetn(presetn), .start(go_load & ~dual_r),
                    .ack(exit_msr_load_ack), .req(exit_msr_load_req), .done(xmsr_done));
  vmxs_step u_pdptr (.pclk(pclk), .presetn(presetn), .start(go_pdptr),
                     .ack(pdptr_load_ack), .req(pdptr_load_req), .done(pdptr_done));

  assign is_fail    = (cause_r != vmxs_pkg::CAUSE_EXIT);
  assign take       = ctrl_r[`VMXS_CTRL_EN] & (state_r == vmxs_pkg::ST_IDLE);
  assign loads_done = dual_r | (host_done & xmsr_done);
  assign pdptr_need = ctrl_r[`VMXS_CTRL_PDPTR] & ~dual_r & phys_addr_ext_enable &
                      paging_enable & ~long_mode_active;
  assign go_save    = (state_nxt == vmxs_pkg::ST_SAVE) & (state_r != vmxs_pkg::ST_SAVE);
  assign go_store   = (state_nxt == vmxs_pkg::ST_STORE) & (state_r != vmxs_pkg::ST_STORE);
  assign go_load    = (state_nxt == vmxs_pkg::ST_LOAD) & (state_r != vmxs_pkg::ST_LOAD);
  assign go_pdptr   = (state_nxt == vmxs_pkg::ST_PDPTR) & (state_r != vmxs_pkg::ST_PDPTR);

  // next-state sequencing
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      vmxs_pkg::ST_IDLE: begin
        if (take & mc_during_entry & ~guest_loaded)
          state_nxt = vmxs_pkg::ST_MC;
        else if (take & (mc_during_entry | fail_guest_req | fail_msr_req | exit_req))
          state_nxt = vmxs_pkg::ST_RECORD;
      end
      vmxs_pkg::ST_RECORD: begin
        state_nxt = is_fail ? vmxs_pkg::ST_LOAD : vmxs_pkg::ST_SAVE;
      end
      vmxs_pkg::ST_SAVE: begin
        if (save_done)
          state_nxt = ctrl_r[`VMXS_CTRL_STORE] ? vmxs_pkg::ST_STORE : vmxs_pkg::ST_LOAD;
      end
      vmxs_pkg::ST_STORE: begin
        if (store_done)
          state_nxt = vmxs_pkg::ST_LOAD;
      end
      vmxs_pkg::ST_LOAD: begin
        if (loads_done)
          state_nxt = pdptr_need ? vmxs_pkg::ST_PDPTR : vmxs_pkg::ST_DONE;
      end
      vmxs_pkg::ST_PDPTR: begin
        if (pdptr_done)
          state_nxt = vmxs_pkg::ST_DONE;
      end
      vmxs_pkg::ST_DONE: state_nxt = vmxs_pkg::ST_IDLE;
      vmxs_pkg::ST_MC:   state_nxt = vmxs_pkg::ST_IDLE;
      default:           state_nxt = vmxs_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      state_r <= vmxs_pkg::ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // capture request details; machine check wins, then guest, register list, exit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_r      <= vmxs_pkg::CAUSE_EXIT;
      gkind_r      <= vmxs_pkg::GQ_NONE;
      idx_r        <= '0;
      dual_r       <= 1'b0;
      nmi_before_r <= 1'b0;
      xbasic_r     <= 16'h0000;
      xqual_r      <= 32'h0000_0000;
      xinfo_in_r   <= 32'h0000_0000;
    end else if (state_nxt == vmxs_pkg::ST_RECORD) begin
      nmi_before_r <= nmi_blocked_before;
      dual_r       <= 1'b0;
      if (mc_during_entry) begin
        cause_r <= vmxs_pkg::CAUSE_MC;
      end else if (fail_guest_req) begin
        cause_r <= vmxs_pkg::CAUSE_GUEST;
        gkind_r <= vmxs_pkg::vmxs_gqual_e'(fail_guest_kind);
      end else if (fail_msr_req) begin
        cause_r <= vmxs_pkg::CAUSE_MSR;
        idx_r   <= fail_msr_index;
      end else begin
        cause_r    <= vmxs_pkg::CAUSE_EXIT;
        dual_r     <= dual_monitor_exit;
        xbasic_r   <= exit_basic;
        xqual_r    <= exit_qual_in;
        xinfo_in_r <= exit_info_in;
      end
    end
  end

  // exit information fields written in the record step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reason_r    <= 32'h0000_0000;
      qual_r      <= 32'h0000_0000;
      xinfo_r     <= 32'h0000_0000;
      last_fail_r <= 1'b0;
    end else if (state_r == vmxs_pkg::ST_RECORD) begin
      last_fail_r <= is_fail;
      unique case (cause_r)
        vmxs_pkg::CAUSE_GUEST: begin
          reason_r <= {1'b1, 15'h0000, `VMXS_BASIC_GUEST};
          qual_r   <= guest_qual(gkind_r);
        end
        vmxs_pkg::CAUSE_MSR: begin
          reason_r <= {1'b1, 15'h0000, `VMXS_BASIC_MSR};
          qual_r   <= 32'(idx_r) + 32'h0000_0001;
        end
        vmxs_pkg::CAUSE_MC: begin
          reason_r <= {1'b1, 15'h0000, `VMXS_BASIC_MC};
          qual_r   <= `VMXS_QUAL_NONE;
        end
        vmxs_pkg::CAUSE_EXIT: begin
          reason_r <= {16'h0000, xbasic_r};
          qual_r   <= xqual_r;
          xinfo_r  <= xinfo_in_r; // failures leave this alone
        end
      endcase
    end
  end

  // control and injection registers; exit record clears valid over a write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `VMXS_CTRL_RST;
      inj_r  <= 32'h0000_0000;
    end else begin
      if (bus.wr_en & (bus.addr == `VMXS_OFF_CTRL))
        ctrl_r <= bus.wdata;
      if ((state_r == vmxs_pkg::ST_RECORD) & ~is_fail)
        inj_r <= {1'b0, inj_r[30:0]};
      else if (bus.wr_en & (bus.addr == `VMXS_OFF_INJ))
        inj_r <= bus.wdata;
    end
  end

  // machine-check outcomes, nmi blocking, monitor clear and completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mcx_r       <= 1'b0;
      secshut_r   <= 1'b0;
      shut_r      <= 1'b0;
      shut_code_r <= 16'h0000;
      nmi_blk_r   <= 1'b0;
      inhibit_r   <= 1'b0;
      done_r      <= 1'b0;
      monclr_r    <= 1'b0;
    end else begin
      mcx_r     <= (state_r == vmxs_pkg::ST_MC) & machine_check_enable;
      secshut_r <= (state_r == vmxs_pkg::ST_MC) & ~machine_check_enable &
                   safer_mode_operation;
      if ((state_r == vmxs_pkg::ST_MC) & ~machine_check_enable & safer_mode_operation)
        shut_code_r <= `VMXS_SHUT_CODE;
      if ((state_r == vmxs_pkg::ST_MC) & ~machine_check_enable & ~safer_mode_operation)
        shut_r <= 1'b1;
      if ((state_r == vmxs_pkg::ST_DONE) & is_fail)
        nmi_blk_r <= nmi_before_r;
      inhibit_r <= (state_nxt != vmxs_pkg::ST_IDLE);
      done_r    <= (state_r == vmxs_pkg::ST_DONE);
      monclr_r  <= go_load & ~is_fail;
    end
  end

  // register read mux
  always_comb begin
    rdata = 32'h0000_0000;
    unique case (bus.addr)
      `VMXS_OFF_CTRL:   rdata = ctrl_r;
      `VMXS_OFF_REASON: rdata = reason_r;
      `VMXS_OFF_QUAL:   rdata = qual_r;
      `VMXS_OFF_INJ:    rdata = inj_r;
      `VMXS_OFF_XINFO:  rdata = xinfo_r;
      `VMXS_OFF_STATUS: begin
        rdata[`VMXS_ST_BUSY]    = (state_r != vmxs_pkg::ST_IDLE);
        rdata[`VMXS_ST_FAIL]    = last_fail_r;
        rdata[`VMXS_ST_SHUT]    = shut_r;
        rdata[`VMXS_ST_NMIBLK]  = nmi_blk_r;
        rdata[`VMXS_ST_MCX]     = mcx_r;
        rdata[`VMXS_ST_SECSHUT] = secshut_r;
      end
      default: rdata = 32'h0000_0000;
    endcase
  end

  assign bus.rdata            = rdata;
  assign bus.hit              = addr_hit(bus.addr);
  assign monitor_clear        = monclr_r;
  assign mc_exception         = mcx_r;
  assign secure_shutdown      = secshut_r;
  assign shutdown_code        = shut_code_r;
  assign shutdown_state       = shut_r;
  assign nmi_block            = nmi_blk_r;
  assign branch_trace_inhibit = inhibit_r;
  assign seq_done             = done_r;

  // record and sequencing checks
  property p_fail_top;
    @(posedge pclk) disable iff (!presetn)
      (state_r == vmxs_pkg::ST_RECORD) & is_fail |=> reason_r[31] && reason_r[30:16] == 15'h0;
  endproperty
  a_fail_top: assert property (p_fail_top) else $error("failure record top bits wrong");

  property p_basic_guest;
    @(posedge pclk) disable iff (!presetn)
      (state_r == vmxs_pkg::ST_RECORD) & (cause_r == vmxs_pkg::CAUSE_GUEST)
      |=> reason_r[15:0] == 16'h0021;
  endproperty
  a_basic_guest: assert property (p_basic_guest) else $error("guest cause not 33");

  property p_basic_msr;
    @(posedge pclk) disable iff (!presetn)
      (state_r == vmxs_pkg::ST_RECORD) & (cause_r == vmxs_pkg::CAUSE_MSR)
      |=> reason_r[15:0] == 16'h0022 && qual_r == 32'($past(idx_r)) + 32'h0000_0001;
  endproperty
  a_basic_msr: assert property (p_basic_msr) else $error("msr cause or index wrong");

  property p_mc_late;
    @(posedge pclk) disable iff (!presetn)
      take & mc_during_entry & guest_loaded |=> ##1 reason_r[15:0] == 16'h0029;
  endproperty
  a_mc_late: assert property (p_mc_late) else $error("late machine check not cause 41");

  property p_inj_keep;
    @(posedge pclk) disable iff (!presetn)
      (state_r == vmxs_pkg::ST_RECORD) & is_fail & ~bus.wr_en |=> $stable(inj_r);
  endproperty
  a_inj_keep: assert property (p_inj_keep) else $error("failure touched injection");

  property p_inj_clear;
    @(posedge pclk) disable iff (!presetn)
      (state_r == vmxs_pkg::ST_RECORD) & ~is_fail |=> !inj_r[31] ##1 guest_save_req;
  endproperty
  a_inj_clear: assert property (p_inj_clear) else $error("exit record order wrong");

  property p_no_save;
    @(posedge pclk) disable iff (!presetn)
      is_fail & (state_r != vmxs_pkg::ST_IDLE) |-> !go_save && !go_store;
  endproperty
  a_no_save: assert property (p_no_save) else $error("failure saved guest state");

  property p_mc_norm;
    @(posedge pclk) disable iff (!presetn)
      take & mc_during_entry & ~guest_loaded & machine_check_enable
      |=> ##1 mc_exception && !secure_shutdown;
  endproperty
  a_mc_norm: assert property (p_mc_norm) else $error("machine check not delivered");

  property p_done_after;
    @(posedge pclk) disable iff (!presetn)
      seq_done |-> $past(loads_done, 2) && !$past(seq_done);
  endproperty
  a_done_after: assert property (p_done_after) else $error("done before loads");

  property p_dual_skip;
    @(posedge pclk) disable iff (!presetn)
      go_load & dual_r |=> !host_load_req && !exit_msr_load_req;
  endproperty
  a_dual_skip: assert property (p_dual_skip) else $error("dual exit loaded host");
endmodule

// >>> verif/tb_top.sv
`timescale 1ns/1ns
`include "vmxs_params.svh"
module tb_top;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q, xi, fidx;
  logic        pready, pslverr, e, nb;
  logic        exit_req = 0, dual_monitor_exit = 0, fail_guest_req = 0, fail_msr_req = 0;
  logic        mc_during_entry = 0, guest_loaded = 0, nmi_blocked_before = 0;
  logic        machine_check_enable = 0, phys_addr_ext_enable = 0, paging_enable = 0;
  logic        long_mode_active = 0, safer_mode_operation = 0;
  logic [15:0] exit_basic = 16'h0, shutdown_code;
  logic [31:0] exit_qual_in = 32'h0, exit_info_in = 32'h0, fail_msr_index = 32'h0;
  logic [1:0]  fail_guest_kind = 2'h0;
  logic        guest_save_ack = 0, msr_store_ack = 0, host_load_ack = 0;
  logic        exit_msr_load_ack = 0, pdptr_load_ack = 0;
  logic        guest_save_req, msr_store_req, host_load_req, exit_msr_load_req;
  logic        pdptr_load_req, monitor_clear, mc_exception, secure_shutdown;
  logic        shutdown_state, nmi_block, branch_trace_inhibit, seq_done;
  logic [3:0]  ev;
  int          n_mismatch = 0, n_tests = 0;
  logic [31:0] ctl = `VMXS_CTRL_RST;

  // clock at 50 MHz
  always #10 pclk = ~pclk;
  assign ev = {seq_done, mc_exception, secure_shutdown, shutdown_state};

  // engines answer after a random delay
  always @(posedge pclk) begin
    guest_save_ack    <= guest_save_req & 1'($urandom_range(0, 1));
    msr_store_ack     <= msr_store_req & 1'($urandom_range(0, 1));
    host_load_ack     <= host_load_req & 1'($urandom_range(0, 1));
    exit_msr_load_ack <= exit_msr_load_req & 1'($urandom_range(0, 1));
    pdptr_load_ack    <= pdptr_load_req & 1'($urandom_range(0, 1));
  end

  vmxs_seq uut (.*);

  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      $display("MISMATCH %s expected %h seen %h", s, x, g);
      n_mismatch++;
    end
  endtask

  // one apb transfer, waits for pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
    @(posedge pclk) penable <= 1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    q = prdata; e = pslverr;
    chk("pready", 32'h0000_0001, 32'(pready));
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask

  // one request cycle, then wait for the events in mask m
  task automatic fire(input int c, input logic [3:0] m);
    int n;
    logic [2:0] pg3;
    logic [3:0] seen;
    nb = 1'($urandom); nmi_blocked_before <= nb;
    // register-load failures always run under pae paging as a corner
    pg3 = (c == 2) ? 3'h6 : 3'($urandom);
    {phys_addr_ext_enable, paging_enable, long_mode_active} <= pg3;
    exit_req <= c == 0; fail_guest_req <= c == 1; fail_msr_req <= c == 2;
    mc_during_entry <= c == 3;
    @(posedge pclk) {exit_req, fail_guest_req, fail_msr_req, mc_during_entry} <= 4'h0;
    @(posedge pclk);
    chk("inhibit", 32'(m != 4'h0), 32'(branch_trace_inhibit));
    seen = 4'h0;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      seen = seen | {guest_save_req, msr_store_req, pdptr_load_req, monitor_clear};
    end while ((ev & m) == 4'h0 && n < 300);
    chk("event", 32'(m), 32'(ev & m));
    chk("steps", 32'(steps(c, m == 4'h8, pg3)), 32'(seen));
    @(posedge pclk);
  endtask

  function automatic logic [31:0] gq(input int k);
    return k == 1 ? `VMXS_QUAL_PDPTR : k == 2 ? `VMXS_QUAL_LINK :
           k == 3 ? `VMXS_QUAL_STI_NMI : `VMXS_QUAL_NONE;
  endfunction

  // guest save, register store, pointer-table load and monitor clear expected
  function automatic logic [3:0] steps(input int c, input logic rec, input logic [2:0] p);
    logic x;
    x = rec & (c == 0);
    return {x, x & ctl[2], rec & ctl[1] & (p == 3'h6) & ~(x & dual_monitor_exit), x};
  endfunction

  task automatic finish_test;
    if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #400000;
    n_mismatch++;
    finish_test;
  end

  initial begin
    void'($urandom(32'hdcef));
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, `VMXS_OFF_CTRL, 0); chk("ctrl", `VMXS_CTRL_RST, q);
    apb(0, 8'h40, 0); chk("slverr", 1, 32'(e));
    // ordinary exit first so info fields hold known values
    exit_basic <= 16'($urandom); exit_qual_in <= $urandom; xi = $urandom;
    exit_info_in <= xi; dual_monitor_exit <= 1'($urandom);
    apb(1, `VMXS_OFF_INJ, 32'h8000_0000);
    fire(0, 4'h8);
    apb(0, `VMXS_OFF_REASON, 0); chk("x_reason", {16'h0, exit_basic}, q);
    apb(0, `VMXS_OFF_QUAL, 0); chk("x_qual", exit_qual_in, q);
    apb(0, `VMXS_OFF_INJ, 0); chk("x_inj", 0, 32'(q[31]));
    apb(0, `VMXS_OFF_XINFO, 0); chk("x_info", xi, q);
    // each guest-state failure kind
    for (int k = 0; k < 4; k++) begin
      fail_guest_kind <= 2'(k); exit_info_in <= $urandom;
      apb(1, `VMXS_OFF_INJ, 32'h8000_0000);
      fire(1, 4'h8);
      apb(0, `VMXS_OFF_REASON, 0); chk("g_reason", 32'h8000_0021, q);
      apb(0, `VMXS_OFF_QUAL, 0); chk("g_qual", gq(k), q);
      apb(0, `VMXS_OFF_INJ, 0); chk("g_inj", 32'h8000_0000, q);
      apb(0, `VMXS_OFF_XINFO, 0); chk("g_info", xi, q);
      chk("nmi_blk", 32'(nb), 32'(nmi_block));
    end
    // register-load failures, boundary and random index
    for (int k = 0; k < 3; k++) begin
      fidx = k == 0 ? 32'h0 : $urandom_range(1, 4000);
      fail_msr_index <= fidx;
      fire(2, 4'h8);
      apb(0, `VMXS_OFF_REASON, 0); chk("m_reason", 32'h8000_0022, q);
      apb(0, `VMXS_OFF_QUAL, 0); chk("m_qual", fidx + 1, q);
    end
    // machine check once guest state is loaded
    guest_loaded <= 1; machine_check_enable <= 1;
    fire(3, 4'h8);
    apb(0, `VMXS_OFF_REASON, 0); chk("mc_reason", 32'h8000_0029, q);
    // enable clear drops a request; then an exit with no store step
    ctl = 32'h0000_0000;
    apb(1, `VMXS_OFF_CTRL, ctl);
    fire(0, 4'h0);
    apb(0, `VMXS_OFF_REASON, 0);
    chk("off_reason", 32'h8000_0029, q);
    ctl = 32'h0000_0001;
    apb(1, `VMXS_OFF_CTRL, ctl);
    exit_basic <= 16'($urandom);
    dual_monitor_exit <= ~dual_monitor_exit;
    fire(0, 4'h8);
    apb(0, `VMXS_OFF_REASON, 0);
    chk("x2_reason", {16'h0, exit_basic}, q);
    // machine checks before guest state loads: exception, then secure shutdown, then shutdown
    guest_loaded <= 0;
    fire(3, 4'h4);
    machine_check_enable <= 0; safer_mode_operation <= 1;
    fire(3, 4'h2);
    chk("code", 32'(`VMXS_SHUT_CODE), 32'(shutdown_code));
    safer_mode_operation <= 0;
    fire(3, 4'h1);
    finish_test;
  end
endmodule
